// ---- mait_defines.svh ----
// constants for the instruction tail datapath
`ifndef MAIT_DEFINES_SVH
`define MAIT_DEFINES_SVH
`define MAIT_DATA_W        8
`define MAIT_ROM_W         14
`define MAIT_ROM_LO_MSB    7
`define MAIT_ROM_HI_LSB    8
`define MAIT_ROM_HI_MSB    13
`define MAIT_TBH_W         6
`define MAIT_TPH_W         2
`define MAIT_FADDR_W       7
`define MAIT_TMODE_RST     8'hFF
`define MAIT_ACC_RST       8'h00
`define MAIT_TBH_RST       6'h00
`define MAIT_NIB_LO_MSB    3
`define MAIT_NIB_HI_LSB    4
`define MAIT_TABLE_CYCLES  2
`endif

// ---- mait_pkg.sv ----
// types for the instruction tail datapath
package mait_pkg;
  typedef enum logic [3:0] {
    MAIT_OP_NONE,
    MAIT_OP_SUB_FILE,
    MAIT_OP_SUB_IMM,
    MAIT_OP_SWAP,
    MAIT_OP_TABLE,
    MAIT_OP_TMODE_LD,
    MAIT_OP_TMODE_RD,
    MAIT_OP_XOR_FILE,
    MAIT_OP_XOR_IMM
  } mait_op_t;

  typedef struct packed {
    mait_op_t    op;
    logic        dest_file;
    logic [6:0]  faddr;
    logic [7:0]  imm;
  } mait_instr_t;

  typedef struct packed {
    logic       carry;
    logic       half_borrow;
    logic       zero;
  } mait_flags_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } mait_fwrite_t;
endpackage : mait_pkg

// ---- mait_sub.sv ----
// subtractor with no-borrow carry and half flags
`timescale 1ns/1ps
`include "mait_defines.svh"
module mait_sub
  import mait_pkg::*;
(
  input  wire logic [7:0] minuend,    // value subtracted from
  input  wire logic [7:0] subtrahend, // working register
  output logic      [7:0] diff,       // result
  output logic            no_borrow,  // no borrow out of bit 7
  output logic            no_borrow_h // no borrow out of bit 3
);
  wire [8:0] full_w = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
  wire [4:0] half_w = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign diff        = full_w[7:0];
  assign no_borrow   = full_w[8];
  assign no_borrow_h = half_w[4];
endmodule : mait_sub

// ---- mait_table_seq.sv ----
// two-cycle program table read sequencer
`timescale 1ns/1ps
`include "mait_defines.svh"
module mait_table_seq
  import mait_pkg::*;
(
  input  wire logic core_clk, // instruction clock
  input  wire logic srst,     // synchronous reset
  input  wire logic start,    // table read issued
  output logic      rom_req,  // first cycle, address valid
  output logic      finish,   // second cycle, word captured
  output logic      busy      // second cycle only, same as finish
);
  typedef enum logic {MAIT_TS_IDLE, MAIT_TS_FETCH} mait_ts_t;
  mait_ts_t st_r;
  mait_ts_t st_nxt;
  assign rom_req = (st_r == MAIT_TS_IDLE) && start;
  assign finish  = (st_r == MAIT_TS_FETCH);
  assign busy    = finish;
  always_comb begin
    case (st_r)
      MAIT_TS_IDLE:  st_nxt = start ? MAIT_TS_FETCH : MAIT_TS_IDLE;
      MAIT_TS_FETCH: st_nxt = MAIT_TS_IDLE;
      default:       st_nxt = MAIT_TS_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) st_r <= MAIT_TS_IDLE;
    else      st_r <= st_nxt;
  end
endmodule : mait_table_seq

// ---- mait_alu.sv ----
// execution datapath for subtract, swap, table read, timer mode and xor
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "mait_defines.svh"
module mait_alu
  import mait_pkg::*;
(
  input  wire logic               core_clk,      // instruction clock
  input  wire logic               srst,          // synchronous reset
  input  wire mait_instr_t        instr,         // decoded instruction
  input  wire logic               instr_valid,   // instruction valid this cycle
  output logic                    instr_ready,   // low in the second cycle of a table read
  input  wire logic [7:0]         file_rdata,    // file register read data
  output mait_fwrite_t            file_wr,       // file register write
  input  wire logic [1:0]         table_pointer_high, // upper table address
  output logic [9:0]              rom_addr,      // program memory address
  output logic                    rom_rd,        // program memory read strobe
  input  wire logic [13:0]        rom_rdata,     // word, one cycle after strobe
  input  wire mait_flags_t        flags_in,      // current status flags
  output mait_flags_t             flags_out,     // flag values to write
  output mait_flags_t             flags_we,      // per-flag write enables
  output logic [7:0]              working_register,    // accumulator
  output logic [5:0]              table_high_byte,     // table high register
  output logic [7:0]              timer_mode_register  // timer mode register
);
  logic [7:0]   acc_r;
  logic [7:0]   acc_nxt;
  logic [5:0]   tbh_r;
  logic [7:0]   tmode_r;
  mait_fwrite_t fwr_r;
  mait_flags_t  fl_r;
  mait_flags_t  flwe_r;

  wire go = instr_valid && instr_ready;
  wire sub_op    = (instr.op == MAIT_OP_SUB_FILE) || (instr.op == MAIT_OP_SUB_IMM);
  wire xor_op    = (instr.op == MAIT_OP_XOR_FILE) || (instr.op == MAIT_OP_XOR_IMM);
  wire file_dest = instr.dest_file &&
                   ((instr.op == MAIT_OP_SUB_FILE) || (instr.op == MAIT_OP_SWAP) ||
                    (instr.op == MAIT_OP_XOR_FILE));

  // operand select: immediate forms use the literal field
  wire [7:0] opnd = (instr.op == MAIT_OP_SUB_IMM || instr.op == MAIT_OP_XOR_IMM) ? instr.imm : file_rdata;

  wire [7:0] sub_res;
  wire       sub_c;
  wire       sub_h;
  mait_sub u_sub (
    .minuend     (opnd),
    .subtrahend  (acc_r),
    .diff        (sub_res),
    .no_borrow   (sub_c),
    .no_borrow_h (sub_h)
  );

  wire [7:0] xor_res  = opnd ^ acc_r;
  wire [7:0] swap_res = {file_rdata[`MAIT_NIB_LO_MSB:0],
                         file_rdata[`MAIT_DATA_W-1:`MAIT_NIB_HI_LSB]};

  logic [7:0] res;
  always_comb begin
    case (instr.op)
      MAIT_OP_SUB_FILE, MAIT_OP_SUB_IMM: res = sub_res;
      MAIT_OP_SWAP:                      res = swap_res;
      MAIT_OP_XOR_FILE, MAIT_OP_XOR_IMM: res = xor_res;
      MAIT_OP_TMODE_RD:                  res = tmode_r;
      default:                           res = acc_r;
    endcase
  end

  wire start_tbl;
  wire tbl_finish;
  wire tbl_busy;
  mait_table_seq u_tseq (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (go && instr.op == MAIT_OP_TABLE),
    .rom_req  (start_tbl),
    .finish   (tbl_finish),
    .busy     (tbl_busy)
  );

  assign instr_ready = !tbl_busy;
  assign rom_rd      = start_tbl;
  assign rom_addr    = {table_pointer_high, acc_r};

  // working register next value
  always_comb begin
    acc_nxt = acc_r;
    if (tbl_finish)
      acc_nxt = rom_rdata[`MAIT_ROM_LO_MSB:0];
    else if (go && !file_dest && instr.op != MAIT_OP_TABLE && instr.op != MAIT_OP_TMODE_LD &&
             instr.op != MAIT_OP_NONE)
      acc_nxt = res;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_r   <= `MAIT_ACC_RST;
      tbh_r   <= `MAIT_TBH_RST;
      tmode_r <= `MAIT_TMODE_RST;
    end else begin
      acc_r <= acc_nxt;
      if (tbl_finish)
        tbh_r <= rom_rdata[`MAIT_ROM_HI_MSB:`MAIT_ROM_HI_LSB];
      if (go && instr.op == MAIT_OP_TMODE_LD)
        tmode_r <= acc_r;
    end
  end

  // file write and flag updates, registered one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fwr_r  <= '0;
      fl_r   <= '0;
      flwe_r <= '0;
    end else begin
      fwr_r.we   <= go && file_dest;
      fwr_r.addr <= instr.faddr;
      fwr_r.data <= res;
      fl_r.carry       <= sub_c;
      fl_r.half_borrow <= sub_h;
      fl_r.zero        <= (res == 8'h00);
      flwe_r.carry       <= go && sub_op;
      flwe_r.half_borrow <= go && sub_op;
      flwe_r.zero        <= go && (sub_op || xor_op);
    end
  end

  assign file_wr             = fwr_r;
  assign flags_out           = fl_r;
  assign flags_we            = flwe_r;
  assign working_register    = acc_r;
  assign table_high_byte     = tbh_r;
  assign timer_mode_register = tmode_r;

  a_sub_acc_update: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SUB_IMM |=> acc_r == $past(instr.imm) - $past(acc_r))
    else $error("immediate subtract result wrong");
  a_sub_file_dest: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SUB_FILE && instr.dest_file |=> file_wr.we && acc_r == $past(acc_r))
    else $error("subtract to file misrouted");
  a_sub_carry: assert property (@(posedge core_clk) disable iff (srst)
    go && sub_op |=> flags_we.carry && flags_out.carry == ($past(opnd) >= $past(acc_r)))
    else $error("subtract carry wrong");
  a_swap_nibbles: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SWAP && !instr.dest_file
    |=> acc_r == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && flags_we == '0)
    else $error("nibble exchange wrong");
  a_table_two_cyc: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TABLE |=> !instr_ready ##1 instr_ready && table_high_byte == $past(rom_rdata[13:8]))
    else $error("table read timing wrong");
  a_tmode_load: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TMODE_LD |=> timer_mode_register == $past(acc_r) && flags_we == '0)
    else $error("timer mode load wrong");
  a_tmode_read: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TMODE_RD |=> acc_r == $past(tmode_r))
    else $error("timer mode readback wrong");
  a_xor_zero_only: assert property (@(posedge core_clk) disable iff (srst)
    go && xor_op |=> flags_we.zero && !flags_we.carry && !flags_we.half_borrow)
    else $error("xor flag enables wrong");
  a_xor_imm_res: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_XOR_IMM |=> acc_r == ($past(instr.imm) ^ $past(acc_r)))
    else $error("immediate xor result wrong");

  // register- and literal-minus-working forms, both destinations for the register form
  a_sub_file_res: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SUB_FILE && instr.dest_file
    |=> file_wr.data == $past(file_rdata) - $past(acc_r))
    else $error("subtract to file data wrong");
  a_sub_file_acc: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SUB_FILE && !instr.dest_file
    |=> acc_r == $past(file_rdata) - $past(acc_r) && !file_wr.we)
    else $error("subtract to working register wrong");
  a_sub_file_addr: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SUB_FILE && instr.dest_file
    |=> file_wr.addr == $past(instr.faddr))
    else $error("subtract file address wrong");
  a_sub_flag_we: assert property (@(posedge core_clk) disable iff (srst)
    go && sub_op
    |=> flags_we.carry && flags_we.half_borrow && flags_we.zero)
    else $error("subtract flag enables wrong");
  a_sub_imm_nofile: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SUB_IMM
    |=> !file_wr.we)
    else $error("immediate subtract wrote a file register");
  a_sub_half: assert property (@(posedge core_clk) disable iff (srst)
    go && sub_op
    |=> flags_out.half_borrow == ($past(opnd[3:0]) >= $past(acc_r[3:0])))
    else $error("subtract half flag wrong");
  a_sub_zero: assert property (@(posedge core_clk) disable iff (srst)
    go && sub_op
    |=> flags_out.zero == ($past(opnd) == $past(acc_r)))
    else $error("subtract zero flag wrong");
  a_carry_we_src: assert property (@(posedge core_clk) disable iff (srst)
    flags_we.carry
    |-> $past(go && sub_op))
    else $error("carry written outside subtract");

  // nibble exchange
  a_swap_file: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SWAP && instr.dest_file
    |=> file_wr.we && file_wr.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && acc_r == $past(acc_r))
    else $error("nibble exchange to file wrong");
  a_swap_addr: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SWAP && instr.dest_file
    |=> file_wr.addr == $past(instr.faddr))
    else $error("nibble exchange address wrong");
  a_swap_flags: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_SWAP
    |=> flags_we == '0)
    else $error("nibble exchange touched flags");

  // table read sequencing and refusal of the busy cycle
  a_table_strobe: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TABLE
    |-> rom_rd && rom_addr == {table_pointer_high, acc_r})
    else $error("table read strobe or address wrong");
  a_table_acc: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TABLE
    |=> ##1 acc_r == $past(rom_rdata[7:0]))
    else $error("table read low byte wrong");
  a_table_no_flags: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TABLE
    |=> flags_we == '0 ##1 flags_we == '0 && !file_wr.we)
    else $error("table read touched flags or file");
  a_table_refuse: assert property (@(posedge core_clk) disable iff (srst)
    !instr_ready
    |=> timer_mode_register == $past(timer_mode_register) && !file_wr.we && flags_we == '0)
    else $error("instruction taken in busy cycle");
  a_rom_rd_only: assert property (@(posedge core_clk) disable iff (srst)
    rom_rd
    |-> go && instr.op == MAIT_OP_TABLE)
    else $error("stray program memory strobe");
  a_busy_one_cyc: assert property (@(posedge core_clk) disable iff (srst)
    !instr_ready
    |=> instr_ready)
    else $error("busy longer than one cycle");
  a_tbh_hold: assert property (@(posedge core_clk) disable iff (srst)
    !tbl_finish
    |=> table_high_byte == $past(table_high_byte))
    else $error("table high register changed");
  a_acc_hold_idle: assert property (@(posedge core_clk) disable iff (srst)
    !go && !tbl_finish
    |=> acc_r == $past(acc_r))
    else $error("working register changed while idle");

  // timer mode load and readback
  a_tmode_ld_acc: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TMODE_LD
    |=> acc_r == $past(acc_r) && !file_wr.we)
    else $error("timer mode load disturbed working register");
  a_tmode_hold: assert property (@(posedge core_clk) disable iff (srst)
    !(go && instr.op == MAIT_OP_TMODE_LD)
    |=> timer_mode_register == $past(timer_mode_register))
    else $error("timer mode register changed without load");
  a_tmode_rd_flags: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TMODE_RD
    |=> flags_we == '0 && !file_wr.we)
    else $error("timer mode readback touched flags");
  a_tmode_rd_keep: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_TMODE_RD
    |=> timer_mode_register == $past(timer_mode_register))
    else $error("timer mode readback altered register");

  // exclusive-or forms
  a_xor_file_dest: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_XOR_FILE && instr.dest_file
    |=> file_wr.we && file_wr.data == ($past(file_rdata) ^ $past(acc_r)) && acc_r == $past(acc_r))
    else $error("xor to file wrong");
  a_xor_file_addr: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_XOR_FILE && instr.dest_file
    |=> file_wr.addr == $past(instr.faddr))
    else $error("xor file address wrong");
  a_xor_file_acc: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_XOR_FILE && !instr.dest_file
    |=> acc_r == ($past(file_rdata) ^ $past(acc_r)))
    else $error("xor to working register wrong");
  a_xor_zero: assert property (@(posedge core_clk) disable iff (srst)
    go && xor_op
    |=> flags_out.zero == ($past(opnd) == $past(acc_r)))
    else $error("xor zero flag wrong");
  a_zero_we_src: assert property (@(posedge core_clk) disable iff (srst)
    flags_we.zero
    |-> $past(go && (sub_op || xor_op)))
    else $error("zero written outside subtract or xor");
  a_xor_imm_nofile: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_XOR_IMM
    |=> !file_wr.we && flags_we.zero && !flags_we.carry)
    else $error("immediate xor routing wrong");
  a_xor_imm_zero: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_XOR_IMM
    |=> flags_out.zero == (($past(instr.imm) ^ $past(acc_r)) == 8'h00))
    else $error("immediate xor zero flag wrong");

  // file write enable only follows a file-destination instruction
  a_file_we_src: assert property (@(posedge core_clk) disable iff (srst)
    go && !file_dest
    |=> !file_wr.we)
    else $error("file written for working destination");
  a_none_no_effect: assert property (@(posedge core_clk) disable iff (srst)
    go && instr.op == MAIT_OP_NONE
    |=> acc_r == $past(acc_r) && flags_we == '0 && !file_wr.we)
    else $error("idle opcode changed state");
endmodule : mait_alu

// ---- mcu_alu_instr_tail_tb_top.sv ----
// self-checking testbench for the instruction tail datapath
`timescale 1ns/1ps
`include "mait_defines.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module mcu_alu_instr_tail_tb_top
  import mait_pkg::*;
  ;
  logic         core_clk = 1'b0;
  logic         srst     = 1'b1;
  mait_instr_t  instr;
  logic         instr_valid;
  logic         instr_ready;
  logic [7:0]   file_rdata;
  mait_fwrite_t file_wr;
  logic [1:0]   tph;
  logic [9:0]   rom_addr;
  logic         rom_rd;
  logic [13:0]  rom_rdata;
  mait_flags_t  flags_in;
  mait_flags_t  flags_out;
  mait_flags_t  flags_we;
  logic [7:0]   working_register;
  logic [5:0]   table_high_byte;
  logic [7:0]   timer_mode_register;
  logic [7:0]   m_acc;
  logic [7:0]   m_tmode;
  logic [5:0]   m_tbh;
  int           fails;
  int           compares;
  int           cycles;
  integer       seed = 32'hA4752CA0;

  mait_alu uut (.core_clk(core_clk), .srst(srst), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .file_rdata(file_rdata), .file_wr(file_wr), .table_pointer_high(tph),
    .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_rdata(rom_rdata), .flags_in(flags_in),
    .flags_out(flags_out), .flags_we(flags_we), .working_register(working_register),
    .table_high_byte(table_high_byte), .timer_mode_register(timer_mode_register));

  always #2 core_clk = ~core_clk;

  // about 900 cycles expected; a hang is cut off well beyond that
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      final_report();
    end
  end

  // {carry, half, zero, result}; carry and half mean no borrow
  function automatic logic [10:0] calc(input mait_op_t op, input logic [7:0] a, input logic [7:0] w);
    logic [7:0] r;
    case (op)
      MAIT_OP_SUB_FILE, MAIT_OP_SUB_IMM: r = a - w;
      MAIT_OP_SWAP: r = {a[3:0], a[7:4]};
      default: r = a ^ w;
    endcase
    return {a >= w, a[3:0] >= w[3:0], r == 8'h00, r};
  endfunction : calc

  task automatic exec(input mait_op_t op, input logic d, input logic [7:0] fr, input logic [7:0] im);
    logic [10:0] e;
    logic [13:0] word;
    logic [6:0]  fa;
    logic        fdest;
    mait_flags_t ewe;
    word  = 14'($random(seed));
    fa    = 7'($random(seed));
    fdest = d && (op inside {MAIT_OP_SUB_FILE, MAIT_OP_SWAP, MAIT_OP_XOR_FILE});
    e     = calc(op, (op inside {MAIT_OP_SUB_IMM, MAIT_OP_XOR_IMM}) ? im : fr, m_acc);
    ewe   = (op inside {MAIT_OP_SUB_FILE, MAIT_OP_SUB_IMM}) ? 3'h7 :
            (op inside {MAIT_OP_XOR_FILE, MAIT_OP_XOR_IMM}) ? 3'h1 : 3'h0;
    @(posedge core_clk);
    instr       <= '{op: op, dest_file: d, faddr: fa, imm: im};
    instr_valid <= 1'b1;
    file_rdata  <= fr;
    tph         <= 2'($random(seed));
    flags_in    <= 3'($random(seed));
    @(negedge core_clk);
    `CHK(rom_rd, op == MAIT_OP_TABLE)
    if (op == MAIT_OP_TABLE) `CHK(rom_addr, {tph, m_acc})
    @(posedge core_clk);
    if (op == MAIT_OP_TABLE) begin
      // a second instruction offered in the busy cycle must be ignored
      rom_rdata <= word;
      instr.op  <= MAIT_OP_XOR_IMM;
      @(negedge core_clk);
      `CHK(instr_ready, 1'b0)
      @(posedge core_clk);
    end
    instr_valid <= 1'b0;
    rom_rdata   <= ~word;
    file_rdata  <= ~fr;
    case (op)
      MAIT_OP_TABLE: {m_tbh, m_acc} = word;
      MAIT_OP_TMODE_LD: m_tmode = m_acc;
      MAIT_OP_TMODE_RD: m_acc = m_tmode;
      MAIT_OP_NONE: m_acc = m_acc;
      default: if (!fdest) m_acc = e[7:0];
    endcase
    @(negedge core_clk);
    `CHK(file_wr.we, fdest)
    if (fdest) `CHK({file_wr.addr, file_wr.data}, {fa, e[7:0]})
    `CHK(flags_we, ewe)
    `CHK(flags_out & flags_we, e[10:8] & ewe)
    `CHK(working_register, m_acc)
    `CHK(table_high_byte, m_tbh)
    `CHK(timer_mode_register, m_tmode)
  endtask : exec

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    instr       = '0;
    instr_valid = 1'b0;
    file_rdata  = 8'h00;
    tph         = 2'h0;
    rom_rdata   = 14'h0000;
    flags_in    = '0;
    m_acc       = `MAIT_ACC_RST;
    m_tmode     = `MAIT_TMODE_RST;
    m_tbh       = `MAIT_TBH_RST;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    `CHK({working_register, timer_mode_register, table_high_byte, instr_ready}, {m_acc, m_tmode, m_tbh, 1'b1})
    $display("test reset done");
    exec(MAIT_OP_TMODE_RD, 1'b1, 8'h00, 8'h00);
    exec(MAIT_OP_SUB_FILE, 1'b1, 8'h00, 8'h00);
    exec(MAIT_OP_SUB_IMM, 1'b0, 8'h00, 8'hFF);
    exec(MAIT_OP_SUB_IMM, 1'b1, 8'h00, 8'h10);
    exec(MAIT_OP_SUB_FILE, 1'b0, 8'h08, 8'h00);
    exec(MAIT_OP_XOR_IMM, 1'b0, 8'h00, 8'hF8);
    exec(MAIT_OP_TABLE, 1'b0, 8'h00, 8'h00);
    exec(MAIT_OP_TMODE_LD, 1'b0, 8'h00, 8'h00);
    exec(MAIT_OP_SWAP, 1'b0, 8'hA5, 8'h00);
    exec(MAIT_OP_XOR_FILE, 1'b1, 8'h3C, 8'h00);
    exec(MAIT_OP_NONE, 1'b0, 8'h5A, 8'hA5);
    $display("test corner cases done");
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst    <= 1'b0;
    m_acc   = `MAIT_ACC_RST;
    m_tmode = `MAIT_TMODE_RST;
    m_tbh   = `MAIT_TBH_RST;
    @(negedge core_clk);
    `CHK({working_register, timer_mode_register, table_high_byte, file_wr.we, flags_we}, {m_acc, m_tmode, m_tbh, 4'h0})
    $display("test mid-run reset done");
    repeat (400) exec(mait_op_t'(4'(1 + ($unsigned($random(seed)) % 8))), 1'($random(seed)),
                      8'($random(seed)), 8'($random(seed)));
    $display("test random sequence done");
    final_report();
  end
endmodule : mcu_alu_instr_tail_tb_top
